// ===== hdl/stec_edge_capture.sv
// Digital-mode readout: sweep timing, edge capture, cache hand-off, supervisor.
module stec_edge_capture
#(
    parameter int unsigned DUTY_WIN_CYC = stec_pkg::DUTY_CYC
)
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   ce_i,
    input  wire logic                   video_i,
    input  wire logic                   dig_button_i,
    input  wire logic                   trig_i,
    input  wire logic                   sweep_i,
    input  wire logic                   write_gate_i,
    input  wire logic                   loop_en_i,
    input  wire logic                   loop_sync_i,
    input  wire logic                   remote_i,
    input  wire logic                   dig_cmd_i,
    input  wire logic [7:0]             bus_main_i,
    input  wire logic [7:0]             bus_grat_i,
    input  wire logic [7:0]             panel_main_i,
    input  wire logic [7:0]             panel_grat_i,
    input  wire logic                   mc_ready_i,
    output logic                        read_tick_o,
    output logic                        x_ramp_gate_o,
    output logic                        y_ramp_gate_o,
    output logic                        tv_sync_o,
    output logic                        blank_o,
    output logic                        grat_sel_o,
    output logic [7:0]                  main_int_o,
    output logic [7:0]                  grat_int_o,
    output logic                        storing_o,
    output logic                        mc_start_o,
    output logic                        mc_done_o,
    output logic                        mc_valid_o,
    output logic                        mc_kind_o,
    output logic [stec_pkg::Y_W-1:0]    mc_data_o,
    output logic [stec_pkg::Y_W-1:0]    mc_xaddr_o
);
    import stec_pkg::*;

    // ======================================================================
    // State
    typedef enum logic [2:0] {
        PH_ACTIVE,
        PH_RETRACE,
        PH_DR_ADDR,
        PH_DR_LOAD,
        PH_DR_SEND,
        PH_DR_CNT
    } stec_phase_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_WAIT_SCAN,
        ST_STORING
    } stec_stor_e;

    typedef struct packed {
        stec_phase_e          phase;
        stec_stor_e           st;
        logic                 sto;
        logic [3:0]           div;
        logic [Y_W-1:0]       y;
        logic [Y_W-1:0]       x;
        logic [Y_W-1:0]       start_x;
        logic [CNT_W-1:0]     cnt;
        logic [CA_W-1:0]      rd_idx;
        logic                 prev;
        logic                 open;
        logic [7:0]           ret;
        logic [NPINS-1:0]     s1;
        logic [NPINS-1:0]     s2;
        logic [NPINS-1:0]     s3;
        logic                 start_p;
        logic                 done_p;
        logic                 out_kind;
        logic [Y_W-1:0]       out_data;
        logic [9:0]           grat_cnt;
        logic [DUTY_W-1:0]    duty_win;
        logic [DUTY_W-1:0]    duty_on;
        logic                 over;
        logic [7:0]           main_int;
        logic [7:0]           grat_int;
    } stec_state_s;

    localparam logic [DUTY_W-1:0] DUTY_LAST = DUTY_W'(DUTY_WIN_CYC - 1);
    localparam logic [DUTY_W-1:0] DUTY_HALF = DUTY_W'(DUTY_WIN_CYC / 2);

    stec_state_s  r_reg;
    stec_state_s  r_next;
    logic         tick;
    logic         scan_start;
    logic         wr_en;
    logic [8:0]   wr_dat;
    logic         btn_rise;
    logic         trig_rise;
    logic         sweep_fall;
    logic         dig_req;
    logic         loop_en_r;
    logic         loop_r;

    stec_cache_if cache_bus ();

    stec_cache_mem u_cache (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .cache     (cache_bus.mem)
    );

    // ======================================================================
    // Helpers
    function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt)
            return 8'(cur + 8'h01);
        else if (cur > tgt)
            return 8'(cur - 8'h01);
        return cur;
    endfunction : step_to

    function automatic logic [7:0] cap_int(input logic [7:0] v, input logic over);
        return (over && v > INT_CAP) ? INT_CAP : v;
    endfunction : cap_int

    // New scan: x steps, per-scan state cleared, storage window opened or closed
    function automatic stec_state_s begin_scan(input stec_state_s s);
        stec_state_s t;
        t       = s;
        t.phase = PH_ACTIVE;
        t.x     = 9'(s.x + 9'h001);
        t.y     = '0;
        t.cnt   = '0;
        t.prev  = 1'b0;
        t.open  = 1'b0;
        if (s.st == ST_WAIT_SCAN)
        begin
            t.st      = ST_STORING;
            t.start_x = t.x;
        end
        else if (s.st == ST_STORING && t.x == s.start_x)
        begin
            t.st     = ST_IDLE;
            t.done_p = 1'b1;
        end
        t.sto = (t.st == ST_STORING);
        return t;
    endfunction : begin_scan

    assign btn_rise   = r_reg.s2[P_BUTTON] & ~r_reg.s3[P_BUTTON];
    assign trig_rise  = r_reg.s2[P_TRIG] & ~r_reg.s3[P_TRIG];
    assign sweep_fall = ~r_reg.s2[P_SWEEP] & r_reg.s3[P_SWEEP];
    assign dig_req    = remote_i ? dig_cmd_i : btn_rise;
    assign loop_en_r  = r_reg.s2[P_LOOPEN];
    assign loop_r     = r_reg.s2[P_LOOP];
    assign tick       = (r_reg.div == PIX_LAST);

    // ======================================================================
    // Next state
    always_comb
    begin
        r_next         = r_reg;
        r_next.start_p = 1'b0;
        r_next.done_p  = 1'b0;
        r_next.s1      = {loop_sync_i, loop_en_i, write_gate_i, sweep_i,
                          trig_i, dig_button_i, video_i};
        r_next.s2      = r_reg.s1;
        r_next.s3      = r_reg.s2;
        r_next.div     = tick ? 4'h0 : 4'(r_reg.div + 4'h1);
        wr_en          = 1'b0;
        wr_dat         = '0;
        scan_start     = 1'b0;

        unique case (r_reg.st)
            ST_IDLE:
                if (dig_req)
                    r_next.st = ST_ARMED;
            ST_ARMED:
                if (trig_rise)
                begin
                    r_next.st      = ST_WAIT_SCAN;
                    r_next.start_p = 1'b1;
                end
            ST_WAIT_SCAN,
            ST_STORING: ;
        endcase

        unique case (r_reg.phase)
            PH_ACTIVE:
                if (tick)
                begin
                    if (r_reg.s2[P_VIDEO] != r_reg.prev)
                    begin
                        r_next.prev = r_reg.s2[P_VIDEO];
                        // A top is refused when no room remains for its bottom
                        if (r_reg.sto && r_reg.s2[P_VIDEO] && r_reg.cnt <= OPEN_MAX)
                        begin
                            wr_en       = 1'b1;
                            wr_dat      = ~r_reg.y;
                            r_next.open = 1'b1;
                            r_next.cnt  = 5'(r_reg.cnt + 5'h01);
                        end
                        else if (r_reg.sto && !r_reg.s2[P_VIDEO] && r_reg.open)
                        begin
                            wr_en       = 1'b1;
                            wr_dat      = ~r_reg.y;
                            r_next.open = 1'b0;
                            r_next.cnt  = 5'(r_reg.cnt + 5'h01);
                        end
                    end
                    if (r_reg.y == Y_LAST)
                    begin
                        r_next.phase = PH_RETRACE;
                        r_next.ret   = '0;
                    end
                    else
                    begin
                        r_next.y = 9'(r_reg.y + 9'h001);
                    end
                end
            PH_RETRACE:
            begin
                // Trace still open at the bottom edge: close it there
                if (r_reg.open)
                begin
                    wr_en       = 1'b1;
                    wr_dat      = Y_BOTTOM;
                    r_next.open = 1'b0;
                    r_next.cnt  = 5'(r_reg.cnt + 5'h01);
                end
                r_next.ret = 8'(r_reg.ret + 8'h01);
                if (r_reg.ret == RET_LAST)
                begin
                    r_next.rd_idx   = '0;
                    r_next.out_data = {4'h0, r_reg.cnt};
                    r_next.out_kind = 1'b1;
                    if (!r_reg.sto)
                    begin
                        scan_start = 1'b1;
                        r_next     = begin_scan(r_next);
                    end
                    else if (r_reg.cnt == '0)
                        r_next.phase = PH_DR_CNT;
                    else
                        r_next.phase = PH_DR_ADDR;
                end
            end
            PH_DR_ADDR:
                r_next.phase = PH_DR_LOAD;
            PH_DR_LOAD:
            begin
                r_next.out_data = cache_bus.rdata;
                r_next.out_kind = 1'b0;
                r_next.phase    = PH_DR_SEND;
            end
            PH_DR_SEND:
                if (mc_ready_i)
                begin
                    if (5'(r_reg.rd_idx + 5'h01) == r_reg.cnt)
                    begin
                        r_next.phase    = PH_DR_CNT;
                        r_next.out_data = {4'h0, r_reg.cnt};
                        r_next.out_kind = 1'b1;
                    end
                    else
                    begin
                        r_next.rd_idx = 5'(r_reg.rd_idx + 5'h01);
                        r_next.phase  = PH_DR_ADDR;
                    end
                end
            PH_DR_CNT:
                if (mc_ready_i)
                begin
                    scan_start = 1'b1;
                    r_next     = begin_scan(r_next);
                end
            default:
                r_next.phase = PH_ACTIVE;
        endcase

        // Graticule window after each plug-in sweep
        if (sweep_fall)
            r_next.grat_cnt = GRAT_LOAD;
        else if (r_reg.grat_cnt != '0)
            r_next.grat_cnt = 10'(r_reg.grat_cnt - 10'h001);

        // Writing duty cycle over a fixed window
        r_next.duty_on  = DUTY_W'(r_reg.duty_on + {14'h0000, r_reg.s2[P_WGATE]});
        r_next.duty_win = DUTY_W'(r_reg.duty_win + 15'h0001);
        if (r_reg.duty_win == DUTY_LAST)
        begin
            r_next.over     = (r_reg.duty_on > DUTY_HALF);
            r_next.duty_win = '0;
            r_next.duty_on  = '0;
        end

        // Intensity: bus value or step toward panel, then limit
        if (remote_i)
        begin
            r_next.main_int = cap_int(bus_main_i, r_reg.over);
            r_next.grat_int = cap_int(bus_grat_i, r_reg.over);
        end
        else
        begin
            r_next.main_int = cap_int(step_to(r_reg.main_int, panel_main_i), r_reg.over);
            r_next.grat_int = cap_int(step_to(r_reg.grat_int, panel_grat_i), r_reg.over);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r_reg <= '0;
        end
        else if (ce_i)
        begin
            r_reg <= r_next;
        end
    end

    // ======================================================================
    // Outputs
    assign cache_bus.ce    = ce_i;
    assign cache_bus.we    = wr_en;
    assign cache_bus.waddr = r_reg.cnt;
    assign cache_bus.wdata = wr_dat;
    assign cache_bus.raddr = r_reg.rd_idx;

    // Loop input replaces both internal gates when enabled
    assign y_ramp_gate_o = loop_en_r ? loop_r : (r_reg.phase == PH_ACTIVE);
    assign x_ramp_gate_o = loop_en_r ? loop_r
                         : !(r_reg.x == X_LAST && r_reg.phase != PH_ACTIVE);
    assign tv_sync_o     = !(y_ramp_gate_o && x_ramp_gate_o);
    assign blank_o       = (r_reg.phase != PH_ACTIVE);
    assign read_tick_o   = tick;
    assign grat_sel_o    = (r_reg.grat_cnt != '0);
    assign main_int_o    = r_reg.main_int;
    assign grat_int_o    = r_reg.grat_int;
    assign storing_o     = (r_reg.st == ST_STORING);
    assign mc_start_o    = r_reg.start_p;
    assign mc_done_o     = r_reg.done_p;
    // Fast point path toward the memory controller side
    assign mc_valid_o    = (r_reg.phase == PH_DR_SEND) || (r_reg.phase == PH_DR_CNT);
    assign mc_kind_o     = r_reg.out_kind;
    assign mc_data_o     = r_reg.out_data;
    assign mc_xaddr_o    = r_reg.x;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_tick_active;
        ce_i && r_reg.phase == PH_ACTIVE && tick && r_reg.y != Y_LAST;
    endsequence
    sequence s_scan_end;
        ce_i && r_reg.phase == PH_ACTIVE && tick && r_reg.y == Y_LAST;
    endsequence
    sequence s_new_scan;
        ce_i && scan_start;
    endsequence
    sequence s_begin;
        r_reg.st == ST_WAIT_SCAN ##0 s_new_scan;
    endsequence

    property p_ycount;
        s_tick_active |=> r_reg.y == 9'($past(r_reg.y) + 9'h001);
    endproperty
    a_ycount: assert property (p_ycount) else $error("vertical count did not step");

    property p_xadv;
        s_new_scan |=> r_reg.x == 9'($past(r_reg.x) + 9'h001) && r_reg.cnt == '0;
    endproperty
    a_xadv: assert property (p_xadv) else $error("scan start did not advance x");

    property p_cap;
        r_reg.cnt <= MAX_PTS;
    endproperty
    a_cap: assert property (p_cap) else $error("point count above limit");

    property p_pair;
        ce_i && r_reg.phase == PH_RETRACE && r_reg.ret == RET_LAST |-> !r_reg.cnt[0];
    endproperty
    a_pair: assert property (p_pair) else $error("odd point count at scan end");

    property p_comp;
        wr_en && r_reg.phase == PH_ACTIVE |-> wr_dat == ~r_reg.y && r_reg.sto;
    endproperty
    a_comp: assert property (p_comp) else $error("stored value not complement");

    property p_blank;
        s_scan_end |=> blank_o [*8];
    endproperty
    a_blank: assert property (p_blank) else $error("beam not blanked in retrace");

    property p_grat;
        ce_i && sweep_fall |=> grat_sel_o [*8];
    endproperty
    a_grat: assert property (p_grat) else $error("graticule not selected");

    property p_loop;
        loop_en_r |-> tv_sync_o == !loop_r && blank_o == (r_reg.phase != PH_ACTIVE);
    endproperty
    a_loop: assert property (p_loop) else $error("loop input did not override");

    property p_begin;
        s_begin |=> r_reg.st == ST_STORING && r_reg.start_x == r_reg.x;
    endproperty
    a_begin: assert property (p_begin) else $error("storage did not begin");

    property p_trig;
        ce_i && r_reg.st == ST_ARMED && trig_rise |=> mc_start_o ##1 !mc_start_o;
    endproperty
    a_trig: assert property (p_trig) else $error("no start pulse on trigger");

    property p_lim;
        ce_i && r_reg.over |=> main_int_o <= INT_CAP && grat_int_o <= INT_CAP;
    endproperty
    a_lim: assert property (p_lim) else $error("intensity not limited");

    property p_remote;
        ce_i && remote_i && !r_reg.over |=> main_int_o == $past(bus_main_i);
    endproperty
    a_remote: assert property (p_remote) else $error("remote intensity not followed");

    property p_count_word;
        r_reg.phase == PH_DR_CNT |-> mc_kind_o && mc_data_o == {4'h0, r_reg.cnt};
    endproperty
    a_count_word: assert property (p_count_word) else $error("bad count word");
endmodule : stec_edge_capture

// ===== hdl/stec_pkg.sv
// Constants and timing for the target edge-capture readout.
//
// Summary of operation
// - Read target as 512 vertical scans, left to right.
// - Captured points come in pairs; every top gets a bottom in the same scan.
// - Each vertical scan holds up to 30 captured points.
// - Stored value is complemented count: 511 top, zero bottom.
// - Horizontal counter advances by one at each new vertical scan.
// - Horizontal count addresses the array; point count of that scan stored there.
// - Each change of thresholded video during storage latches the vertical count as a point, until the scan holds 30.
// - Points of one scan sit in a fast local cache.
// - Read clock made here; ramp gates derived from it.
// - TV sync from ramp gates; loop sync input overrides the gates.
// - After each plug-in sweep, graticule source selected briefly.
// - Reading beam blanked during every retrace.
// - Supervisor watches writing duty cycle and limits intensity.
// - Remote: intensity follows bus; local: step outputs toward panel.
// - Supervisor starts storage on bus command (remote) or button (local).
// - Dedicated fast data path to memory controller side.
// - Vertical count 0 to 511; sample comparator at each increment.
// - Storage begins at the next new scan after the first trigger following a digitize request.
// - Storage runs until the beam returns to the starting scan.
package stec_pkg;
    // ======================================================================
    // Geometry
    localparam int          Y_W       = 9;
    localparam int          CNT_W     = 5;
    localparam int          CA_W      = 5;
    localparam int          CA_DEPTH  = 32;
    localparam logic [8:0]  Y_LAST    = 9'h1FF;
    localparam logic [8:0]  X_LAST    = 9'h1FF;
    localparam logic [4:0]  MAX_PTS   = 5'h1E;
    localparam logic [4:0]  OPEN_MAX  = 5'h1C;
    localparam logic [8:0]  Y_BOTTOM  = 9'h000;
    // ======================================================================
    // Pin bit positions
    localparam int          NPINS     = 7;
    localparam int          P_VIDEO   = 0;
    localparam int          P_BUTTON  = 1;
    localparam int          P_TRIG    = 2;
    localparam int          P_SWEEP   = 3;
    localparam int          P_WGATE   = 4;
    localparam int          P_LOOPEN  = 5;
    localparam int          P_LOOP    = 6;
    // ======================================================================
    // Timing
    localparam int          CLK_NS      = 40;
    localparam int          PIX_NS      = 80;
    localparam int          RETRACE_NS  = 2000;
    localparam int          GRAT_NS     = 20000;
    localparam int          DUTY_WIN_NS = 1000000;
    localparam int          PIX_CYC     = (PIX_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RET_CYC     = (RETRACE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          GRAT_CYC    = (GRAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          DUTY_CYC    = DUTY_WIN_NS / CLK_NS;
    localparam logic [3:0]  PIX_LAST    = 4'(PIX_CYC - 1);
    localparam logic [7:0]  RET_LAST    = 8'(RET_CYC - 1);
    localparam logic [9:0]  GRAT_LOAD   = 10'(GRAT_CYC);
    localparam int          DUTY_W      = 15;
    // ======================================================================
    // Intensity
    localparam logic [7:0]  INT_CAP     = 8'h80;
endpackage : stec_pkg

// ===== hdl/stec_cache_if.sv
// Carrier between the capture logic and its point cache.
interface stec_cache_if;
    import stec_pkg::*;
    logic             ce;
    logic             we;
    logic [CA_W-1:0]  waddr;
    logic [Y_W-1:0]   wdata;
    logic [CA_W-1:0]  raddr;
    logic [Y_W-1:0]   rdata;
    modport ctl (output ce, we, waddr, wdata, raddr, input rdata);
    modport mem (input ce, we, waddr, wdata, raddr, output rdata);
endinterface : stec_cache_if

// ===== hdl/stec_cache_mem.sv
// Fast per-scan point cache with registered read data.
module stec_cache_mem
    import stec_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    reset_n_i,
    stec_cache_if.mem    cache
);
    typedef struct packed {
        logic [CA_DEPTH-1:0][Y_W-1:0] mem;
        logic [Y_W-1:0]               rdata;
    } stec_mem_s;

    stec_mem_s r_reg;
    stec_mem_s r_next;

    always_comb
    begin
        r_next       = r_reg;
        r_next.rdata = r_reg.mem[cache.raddr];
        if (cache.we)
        begin
            r_next.mem[cache.waddr] = cache.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            r_reg <= '0;
        end
        else if (cache.ce)
        begin
            r_reg <= r_next;
        end
    end

    assign cache.rdata = r_reg.rdata;
endmodule : stec_cache_mem

// ===== verification/stec_mc_model.sv
// Memory controller model that takes words from the drain port.
module stec_mc_model
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       valid_i,
    input  wire logic       kind_i,
    input  wire logic [8:0] data_i,
    input  wire logic [8:0] xaddr_i,
    output logic            ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] pts [0:31];
    logic [8:0] p0, p1, cnt, cx;
    int         np, ncnt;
    // ======================================================================
    // Ready every other cycle, so the drain always meets back-pressure
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            ready_o <= 1'b0;
            np      <= 0;
            ncnt    <= 0;
        end
        else
        begin
            ready_o <= !ready_o;
            if (valid_i && ready_o && !kind_i)
            begin
                pts[np[4:0]] <= data_i;
                np           <= np + 1;
            end
            if (valid_i && ready_o && kind_i)
            begin
                {p0, p1, cnt, cx} <= {pts[0], pts[1], data_i, xaddr_i};
                np                <= 0;
                ncnt              <= ncnt + 1;
            end
        end
endmodule : stec_mc_model

// ===== verification/stec_edge_capture_bench.sv
// Self-checking bench for the edge-capture readout.
module stec_edge_capture_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 0, reset_n_i = 0, video = 0, trig = 0, sweep = 0, ready, wgate = 0;
    logic       loop_en = 0, loop_sync = 0, remote = 0, dig_cmd = 0;
    logic [7:0] bus_main = 8'h00, panel_main = 8'h00, main_int, grat_int;
    logic       tick, xg, yg, tv, blank, grat, storing, start, valid, kind;
    logic [8:0] data, xaddr, x0;
    int         miscompares = 0, cmp_count = 0, k, n;
    // ======================================================================
    // Clock, design and partner
    initial forever #20 clk_i = !clk_i;
    stec_edge_capture #(.DUTY_WIN_CYC(64)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .video_i(video), .dig_button_i(1'b0), .trig_i(trig), .sweep_i(sweep),
        .write_gate_i(wgate), .loop_en_i(loop_en), .loop_sync_i(loop_sync), .remote_i(remote),
        .dig_cmd_i(dig_cmd), .bus_main_i(bus_main), .bus_grat_i(8'h00),
        .panel_main_i(panel_main), .panel_grat_i(panel_main), .mc_ready_i(ready),
        .read_tick_o(tick), .x_ramp_gate_o(xg), .y_ramp_gate_o(yg), .tv_sync_o(tv),
        .blank_o(blank), .grat_sel_o(grat), .main_int_o(main_int), .grat_int_o(grat_int),
        .storing_o(storing), .mc_start_o(start), .mc_done_o(), .mc_valid_o(valid),
        .mc_kind_o(kind), .mc_data_o(data), .mc_xaddr_o(xaddr));
    stec_mc_model i_mc (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(valid),
        .kind_i(kind), .data_i(data), .xaddr_i(xaddr), .ready_o(ready));
    // ======================================================================
    // Shared tasks
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask : cyc
    task automatic timed_out(input int c);
        if (c >= 3000)
        begin
            miscompares++;
            $display("BAD %0t wait ran out", $time);
            print_verdict();
        end
    endtask : timed_out
    // ======================================================================
    // Scenarios
    task automatic t_tick();
        n = 0;
        repeat (40) @(negedge clk_i) n += int'(tick);
        chk(9'(n), 9'h014);
    endtask : t_tick
    task automatic t_intensity();
        @(negedge clk_i) chk(9'(main_int), 9'h000);
        @(posedge clk_i) {remote, bus_main} <= {1'b1, 8'h12};
        cyc(4);
        @(negedge clk_i) chk(9'(main_int), 9'h012);
        @(posedge clk_i) {remote, panel_main} <= {1'b0, 8'h05};
        cyc(20);
        @(negedge clk_i) chk(9'(main_int), 9'h005);
        chk(9'(grat_int), 9'h005);
    endtask : t_intensity
    // ======================================================================
    // Writing gate held on past half the window, then released
    task automatic t_duty();
        @(posedge clk_i) {remote, bus_main, wgate} <= {1'b1, 8'hFF, 1'b1};
        cyc(200);
        @(negedge clk_i) chk(9'(main_int), 9'h080);
        @(posedge clk_i) wgate <= 1'b0;
        cyc(200);
        @(negedge clk_i) chk(9'(main_int), 9'h0FF);
    endtask : t_duty
    task automatic t_grat();
        @(posedge clk_i) sweep <= 1'b1;
        cyc(6);
        sweep <= 1'b0;
        cyc(10);
        @(negedge clk_i) chk(9'(grat), 9'h001);
        cyc(500);
        @(negedge clk_i) chk(9'(grat), 9'h000);
    endtask : t_grat
    task automatic t_loop();
        @(posedge clk_i) {loop_en, loop_sync} <= 2'b11;
        cyc(6);
        @(negedge clk_i) chk(9'({xg, yg, tv}), 9'h006);
        @(posedge clk_i) loop_sync <= 1'b0;
        cyc(6);
        @(negedge clk_i) chk(9'({xg, yg, tv}), 9'h001);
        @(posedge clk_i) loop_en <= 1'b0;
    endtask : t_loop
    task automatic t_store();
        @(posedge clk_i) {remote, dig_cmd} <= 2'b11;
        @(posedge clk_i) dig_cmd <= 1'b0;
        cyc(3);
        trig <= 1'b1;
        for (k = 0; k < 3000 && start !== 1'b1; k++) @(negedge clk_i);
        timed_out(k);
        chk(9'(start), 9'h001);
        @(posedge clk_i) trig <= 1'b0;
        for (k = 0; k < 3000 && blank !== 1'b1; k++) @(negedge clk_i);
        timed_out(k);
        for (k = 0; k < 3000 && !(storing === 1'b1 && blank === 1'b0); k++) @(negedge clk_i);
        timed_out(k);
        @(posedge clk_i) cyc(100);
        video <= 1'b1;
        cyc(100);
        video <= 1'b0;
        n = i_mc.ncnt;
        for (k = 0; k < 3000 && i_mc.ncnt == n; k++) @(negedge clk_i);
        timed_out(k);
        chk(i_mc.cnt, 9'h002);
        chk(i_mc.p0 - i_mc.p1, 9'h032);
        chk(9'(i_mc.p0[8]), 9'h001);
        x0 = i_mc.cx;
        n = i_mc.ncnt;
        for (k = 0; k < 3000 && i_mc.ncnt == n; k++) @(negedge clk_i);
        timed_out(k);
        chk(i_mc.cx, x0 + 9'h001);
        chk(i_mc.cnt, 9'h000);
    endtask : t_store
    initial
    begin
        cyc(3);
        reset_n_i <= 1'b1;
        cyc(4);
        t_tick();
        t_intensity();
        t_grat();
        t_loop();
        t_duty();
        t_store();
        print_verdict();
    end
endmodule : stec_edge_capture_bench
